// file: design/eeprom_slave.sv
`include "serial_link_cfg.svh"

module eeprom_slave
	import serial_link_pkg::*;
#(
	parameter int unsigned WRITE_CYCLE_CLKS = `WRITE_CYCLE_CLKS
)
(
	input  wire logic     rst_in,
	input  wire logic     wp_in,
	output logic          busy_out,
	serial_link_if.dev    link
);

	// ------------------------------------------------------------------------
	// Storage and state
	// ------------------------------------------------------------------------
	logic [7:0]  mem [`MEM_BYTES];
	logic        mem_we;

	logic        scl_m_q;
	logic        scl_s_q;
	logic        scl_p_q;
	logic        sda_m_q;
	logic        sda_s_q;
	logic        sda_p_q;
	logic        wp_m_q;
	logic        wp_s_q;

	dev_state_t  state_q;
	dev_state_t  state_d;
	dev_state_t  nxt_q;
	dev_state_t  nxt_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  sh_q;
	logic [7:0]  sh_d;
	logic [7:0]  ptr_q;
	logic [7:0]  ptr_d;
	logic [7:0]  wdata_q;
	logic [7:0]  wdata_d;
	logic        pend_q;
	logic        pend_d;
	logic        mack_q;
	logic        mack_d;
	logic        oe_n_q;
	logic        oe_n_d;
	logic [15:0] busy_q;
	logic [15:0] busy_d;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic [7:0]  rd_byte;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// The pins come from the master's clock domain, so each passes two
	// flops; the third stage on scl and sda only serves edge detection.
	always_ff @(posedge link.link_clk)
	begin
		if (rst_in)
		begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			wp_m_q  <= 1'b0;
			wp_s_q  <= 1'b0;
		end
		else
		begin
			scl_m_q <= link.scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= link.sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			wp_m_q  <= wp_in;
			wp_s_q  <= wp_m_q;
		end
	end

	assign scl_rise   = scl_s_q & ~scl_p_q;
	assign scl_fall   = ~scl_s_q & scl_p_q;
	assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign rd_byte    = mem[ptr_q];

	// ------------------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		nxt_d   = nxt_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		wdata_d = wdata_q;
		pend_d  = pend_q;
		mack_d  = mack_q;
		oe_n_d  = oe_n_q;
		mem_we  = 1'b0;
		busy_d  = (busy_q != 16'h0000) ? busy_q - 16'h0001 : busy_q;
		if (stop_cond)
		begin
			state_d = S_IDLE;
			oe_n_d  = 1'b1;
			if (pend_q)
			begin
				mem_we = 1'b1;
				pend_d = 1'b0;
				ptr_d  = ptr_q + 8'h01;
				busy_d = WRITE_CYCLE_CLKS[15:0];
			end
		end
		else if (start_cond)
		begin
			// A repeated START abandons an unfinished write.
			state_d = S_DEV;
			cnt_d   = 4'h0;
			oe_n_d  = 1'b1;
			pend_d  = 1'b0;
		end
		else if (scl_rise)
		begin
			case (state_q)
				S_DEV, S_WORD, S_WDATA:
				begin
					if (cnt_q != `BYTE_BITS)
					begin
						sh_d  = {sh_q[6:0], sda_s_q};
						cnt_d = cnt_q + 4'h1;
					end
				end
				S_MACK:
				begin
					mack_d = ~sda_s_q;
				end
				default:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			case (state_q)
				S_DEV:
				begin
					if (cnt_q == `BYTE_BITS)
					begin
						if (sh_q[7:1] == `SLAVE_ADDR && busy_q == 16'h0000)
						begin
							oe_n_d  = 1'b0;
							state_d = S_ACK;
							nxt_d   = (sh_q[0] == `RW_READ) ? S_TX : S_WORD;
						end
						else
						begin
							state_d = S_WAIT;
						end
					end
				end
				S_WORD:
				begin
					if (cnt_q == `BYTE_BITS)
					begin
						ptr_d   = sh_q;
						oe_n_d  = 1'b0;
						state_d = S_ACK;
						nxt_d   = S_WDATA;
					end
				end
				S_WDATA:
				begin
					if (cnt_q == `BYTE_BITS)
					begin
						if (wp_s_q)
						begin
							state_d = S_WAIT;
						end
						else
						begin
							wdata_d = sh_q;
							pend_d  = 1'b1;
							oe_n_d  = 1'b0;
							state_d = S_ACK;
							nxt_d   = S_WAIT;
						end
					end
				end
				S_ACK:
				begin
					oe_n_d  = 1'b1;
					cnt_d   = 4'h0;
					state_d = nxt_q;
					if (nxt_q == S_TX)
					begin
						oe_n_d  = rd_byte[7];
						sh_d    = {rd_byte[6:0], 1'b0};
						ptr_d   = ptr_q + 8'h01;
						cnt_d   = 4'h1;
					end
				end
				S_TX:
				begin
					if (cnt_q == `BYTE_BITS)
					begin
						oe_n_d  = 1'b1;
						mack_d  = 1'b0;
						state_d = S_MACK;
					end
					else
					begin
						oe_n_d  = sh_q[7];
						sh_d    = {sh_q[6:0], 1'b0};
						cnt_d   = cnt_q + 4'h1;
					end
				end
				S_MACK:
				begin
					if (mack_q)
					begin
						oe_n_d  = rd_byte[7];
						sh_d    = {rd_byte[6:0], 1'b0};
						ptr_d   = ptr_q + 8'h01;
						cnt_d   = 4'h1;
						state_d = S_TX;
					end
					else
					begin
						state_d = S_WAIT;
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge link.link_clk)
	begin
		if (rst_in)
		begin
			state_q <= S_IDLE;
			nxt_q   <= S_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			ptr_q   <= 8'h00;
			wdata_q <= 8'h00;
			pend_q  <= 1'b0;
			mack_q  <= 1'b0;
			oe_n_q  <= 1'b1;
			busy_q  <= 16'h0000;
		end
		else
		begin
			state_q <= state_d;
			nxt_q   <= nxt_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			wdata_q <= wdata_d;
			pend_q  <= pend_d;
			mack_q  <= mack_d;
			oe_n_q  <= oe_n_d;
			busy_q  <= busy_d;
		end
	end

	// The array has no reset: non-volatile contents are not cleared.
	always_ff @(posedge link.link_clk)
	begin
		if (mem_we)
		begin
			mem[ptr_q] <= wdata_q;
		end
	end

	assign link.sda_dev_out  = 1'b0;
	assign link.sda_dev_oe_n = oe_n_q;
	assign busy_out          = (busy_q != 16'h0000);

endmodule

// file: design/serial_link_cfg.svh
`ifndef SERIAL_LINK_CFG_SVH
`define SERIAL_LINK_CFG_SVH

// ----------------------------------------------------------------------------
// Memory and addressing
// ----------------------------------------------------------------------------
`define SLAVE_ADDR             7'h50
`define MEM_BYTES              256
`define BYTE_BITS              4'd8
`define RW_READ                1'b1
`define RW_WRITE               1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ                 10000000
`define POWER_UP_READ_WAIT_MS  270
`define POWER_UP_WRITE_WAIT_MS 270
`define PWR_UP_WAIT_CLKS       (`POWER_UP_WRITE_WAIT_MS * (`CLK_HZ / 1000))
`define QTR_CLKS               8'd5
`define WRITE_CYCLE_CLKS       2000

`endif

// file: design/serial_link_pkg.sv
package serial_link_pkg;

	typedef enum logic [3:0] {
		S_IDLE,
		S_DEV,
		S_WORD,
		S_WDATA,
		S_ACK,
		S_TX,
		S_MACK,
		S_WAIT
	} dev_state_t;

	typedef enum logic [2:0] {
		H_PWR,
		H_IDLE,
		H_START,
		H_BYTE,
		H_STOP
	} host_state_t;

	typedef enum logic [2:0] {
		SQ_DEVW,
		SQ_WORD,
		SQ_WDATA,
		SQ_DEVR,
		SQ_READ
	} seq_t;

	typedef enum logic [1:0] {
		OP_WRITE,
		OP_RAND_READ,
		OP_CUR_READ
	} op_t;

endpackage

// file: design/serial_link_if.sv
interface serial_link_if (
	input  wire logic link_clk
);
	logic scl;
	logic sda;
	logic sda_dev_out;
	logic sda_dev_oe_n;
	logic sda_host_out;
	logic sda_host_oe_n;

	// Open-drain wire with pull-up: low whenever either end drives a zero.
	assign sda = (sda_dev_oe_n | sda_dev_out) & (sda_host_oe_n | sda_host_out);

	modport dev (
		input  link_clk,
		input  scl,
		input  sda,
		output sda_dev_out,
		output sda_dev_oe_n
	);

	modport host (
		input  sda,
		output scl,
		output sda_host_out,
		output sda_host_oe_n
	);
endinterface

// file: design/bus_master.sv
`include "serial_link_cfg.svh"

module bus_master
	import serial_link_pkg::*;
#(
	parameter int unsigned PWR_UP_WAIT_CLKS = `PWR_UP_WAIT_CLKS
)
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       cmd_valid_in,
	output logic            cmd_ready_out,
	input  wire op_t        cmd_op_in,
	input  wire logic [7:0] cmd_addr_in,
	input  wire logic [7:0] cmd_data_in,
	input  wire logic [7:0] cmd_len_in,
	output logic [7:0]      rd_data_out,
	output logic            rd_valid_out,
	output logic            done_out,
	output logic            nack_out,
	serial_link_if.host     link
);

	host_state_t hst_q, hst_d;
	seq_t        seq_q, seq_d;
	op_t         op_q, op_d;
	logic [7:0]  addr_q, addr_d, data_q, data_d, len_q, len_d, sh_q, sh_d;
	logic [7:0]  div_q, div_d, rdat_q, rdat_d;
	logic [1:0]  qtr_q, qtr_d;
	logic [3:0]  bit_q, bit_d;
	logic [21:0] pwr_q, pwr_d;
	logic        scl_q, scl_d, oe_n_q, oe_n_d, ack_q, ack_d, retry_q, retry_d;
	logic        rval_q, rval_d, done_q, done_d, nack_q, nack_d;
	logic        sda_m_q, sda_s_q, tick, rx;
	logic [7:0]  txb;

	// Byte that the master sends in each step of a transaction.
	function automatic logic [7:0] tx_byte(seq_t s, logic [7:0] a, logic [7:0] d);
		case (s)
			SQ_DEVW: tx_byte = {`SLAVE_ADDR, `RW_WRITE};
			SQ_DEVR: tx_byte = {`SLAVE_ADDR, `RW_READ};
			SQ_WORD: tx_byte = a;
			default: tx_byte = d;
		endcase
	endfunction

	assign tick = (div_q == `QTR_CLKS - 8'd1);
	assign rx   = (seq_q == SQ_READ);
	// A select on a function result is refused by strict front ends, so the byte is a net.
	assign txb  = tx_byte(seq_q, addr_q, data_q);

	always_comb
	begin
		hst_d = hst_q; seq_d = seq_q; op_d = op_q; addr_d = addr_q; data_d = data_q;
		len_d = len_q; sh_d = sh_q; rdat_d = rdat_q; qtr_d = qtr_q; bit_d = bit_q;
		pwr_d = pwr_q; scl_d = scl_q; oe_n_d = oe_n_q; ack_d = ack_q; retry_d = retry_q;
		nack_d = nack_q; rval_d = 1'b0; done_d = 1'b0;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		case (hst_q)
			H_PWR:
			begin
				if (pwr_q == 22'(PWR_UP_WAIT_CLKS - 1))
					hst_d = H_IDLE;
				else
					pwr_d = pwr_q + 22'h1;
			end
			H_IDLE:
			begin
				div_d = 8'h00;
				qtr_d = 2'h0;
				if (cmd_valid_in)
				begin
					op_d = cmd_op_in; addr_d = cmd_addr_in; data_d = cmd_data_in;
					len_d = cmd_len_in; nack_d = 1'b0; hst_d = H_START;
					seq_d = (cmd_op_in == OP_CUR_READ) ? SQ_DEVR : SQ_DEVW;
				end
			end
			H_START:
			begin
				if (tick)
				begin
					qtr_d = qtr_q + 2'h1;
					case (qtr_q)
						2'h0: oe_n_d = 1'b1;
						2'h1: scl_d = 1'b1;
						2'h2: oe_n_d = 1'b0;
						default:
						begin
							scl_d = 1'b0; bit_d = 4'h0; hst_d = H_BYTE;
						end
					endcase
				end
			end
			H_BYTE:
			begin
				if (tick)
				begin
					qtr_d = qtr_q + 2'h1;
					case (qtr_q)
						2'h0:
						begin
							if (bit_q != `BYTE_BITS)
								oe_n_d = rx | txb[3'(7 - bit_q)];
							else
								oe_n_d = ~rx | (len_q == 8'h00);
						end
						2'h1: scl_d = 1'b1;
						2'h2:
						begin
							if (bit_q != `BYTE_BITS && rx)
								sh_d = {sh_q[6:0], sda_s_q};
							ack_d = ~sda_s_q;
						end
						default:
						begin
							scl_d = 1'b0;
							bit_d = bit_q + 4'h1;
							if (bit_q == `BYTE_BITS)
							begin
								bit_d = 4'h0;
								if (rx)
								begin
									rdat_d = sh_q; rval_d = 1'b1; len_d = len_q - 8'h01;
									if (len_q == 8'h00)
										hst_d = H_STOP;
								end
								else if (!ack_q)
								begin
									// Device address not taken: device busy, so poll again; any other refused byte sets nack.
									retry_d = (seq_q == SQ_DEVW || seq_q == SQ_DEVR);
									nack_d = ~retry_d;
									hst_d = H_STOP;
								end
								else
								begin
									case (seq_q)
										SQ_DEVW: seq_d = SQ_WORD;
										SQ_WORD:
										begin
											seq_d = (op_q == OP_WRITE) ? SQ_WDATA : SQ_DEVR;
											if (op_q != OP_WRITE)
												hst_d = H_START;
										end
										SQ_DEVR: seq_d = SQ_READ;
										default: hst_d = H_STOP;
									endcase
								end
							end
						end
					endcase
				end
			end
			default:
			begin
				if (tick)
				begin
					qtr_d = qtr_q + 2'h1;
					case (qtr_q)
						2'h0: oe_n_d = 1'b0;
						2'h1: scl_d = 1'b1;
						2'h2: oe_n_d = 1'b1;
						default:
						begin
							retry_d = 1'b0;
							seq_d = (op_q == OP_CUR_READ) ? SQ_DEVR : SQ_DEVW;
							hst_d = retry_q ? H_START : H_IDLE;
							done_d = ~retry_q;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			hst_q <= H_PWR; seq_q <= SQ_DEVW; op_q <= OP_WRITE; addr_q <= 8'h00;
			data_q <= 8'h00; len_q <= 8'h00; sh_q <= 8'h00; rdat_q <= 8'h00;
			div_q <= 8'h00; qtr_q <= 2'h0; bit_q <= 4'h0; pwr_q <= 22'h0;
			scl_q <= 1'b1; oe_n_q <= 1'b1; ack_q <= 1'b0; retry_q <= 1'b0;
			rval_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0;
			sda_m_q <= 1'b1; sda_s_q <= 1'b1;
		end
		else
		begin
			hst_q <= hst_d; seq_q <= seq_d; op_q <= op_d; addr_q <= addr_d;
			data_q <= data_d; len_q <= len_d; sh_q <= sh_d; rdat_q <= rdat_d;
			div_q <= div_d; qtr_q <= qtr_d; bit_q <= bit_d; pwr_q <= pwr_d;
			scl_q <= scl_d; oe_n_q <= oe_n_d; ack_q <= ack_d; retry_q <= retry_d;
			rval_q <= rval_d; done_q <= done_d; nack_q <= nack_d;
			sda_m_q <= link.sda; sda_s_q <= sda_m_q;
		end
	end

	assign link.scl           = scl_q;
	assign link.sda_host_out  = 1'b0;
	assign link.sda_host_oe_n = oe_n_q;
	assign cmd_ready_out      = (hst_q == H_IDLE);
	assign rd_data_out        = rdat_q;
	assign rd_valid_out       = rval_q;
	assign done_out           = done_q;
	assign nack_out           = nack_q;

endmodule

// file: verification/link_checker.sv
module link_checker (
	input  wire logic link_clk,
	input  wire logic rst_in,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sda_dev_out,
	input  wire logic sda_dev_oe_n,
	input  wire logic sda_host_out,
	input  wire logic sda_host_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	// An acknowledge followed by a zero byte keeps data low for nine 2 us slots,
	// about 1500 link clocks, so the limit sits just above that.
	logic [11:0] low_q;
	logic [11:0] low_d;

	always_comb
	begin
		low_d = sda_dev_oe_n ? 12'h000 : low_q + 12'h001;
	end

	always_ff @(posedge link_clk)
	begin
		low_q <= rst_in ? 12'h000 : low_d;
	end

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst_in);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	property p_dev_od;
		sda_dev_out == 1'b0;
	endproperty
	a_dev_od: assert property (p_dev_od) else $error("device data output not zero");

	property p_host_od;
		sda_host_out == 1'b0;
	endproperty
	a_host_od: assert property (p_host_od) else $error("master data output not zero");

	property p_dev_chg_scl_low;
		$changed(sda_dev_oe_n) |-> !scl;
	endproperty
	a_dev_chg_scl_low: assert property (p_dev_chg_scl_low) else $error("device moved data");

	property p_frame_by_host;
		($changed(sda) && scl && $past(scl)) |-> $changed(sda_host_oe_n);
	endproperty
	a_frame_by_host: assert property (p_frame_by_host) else $error("framing not by master");

	property p_scl_low_max;
		$fell(scl) |-> ##[1:100] $rose(scl);
	endproperty
	a_scl_low_max: assert property (p_scl_low_max) else $error("clock low too long");

	property p_dev_low_max;
		low_q < 12'd1600;
	endproperty
	a_dev_low_max: assert property (p_dev_low_max) else $error("device held data too long");

	property p_start_then_clock;
		($fell(sda) && scl && $past(scl)) |-> ##[1:100] $fell(scl);
	endproperty
	a_start_then_clock: assert property (p_start_then_clock) else $error("no clock after start");

	property p_stop_holds_scl;
		($rose(sda) && scl && $past(scl)) |=> scl [*8];
	endproperty
	a_stop_holds_scl: assert property (p_stop_holds_scl) else $error("clock fell after stop");
endmodule

// file: verification/tb.sv
module tb
	import serial_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk_in;
	logic       link_clk;
	logic       rst_in;
	logic       wp_in;
	logic       busy;
	logic       cmd_valid_in;
	logic       cmd_ready;
	op_t        cmd_op_in;
	logic [7:0] cmd_addr_in;
	logic [7:0] cmd_data_in;
	logic [7:0] cmd_len_in;
	logic [7:0] rd_data;
	logic       rd_valid;
	logic       done;
	logic       nack;
	logic [7:0] mem [256];
	int         ptr;
	int         errors;
	int         n_checks;
	int         i;
	logic [7:0] ra;

	serial_link_if serial_link_if_i (.link_clk(link_clk));

	eeprom_slave #(.WRITE_CYCLE_CLKS(400)) eeprom_slave_i (
		.rst_in(rst_in), .wp_in(wp_in), .busy_out(busy), .link(serial_link_if_i)
	);

	bus_master #(.PWR_UP_WAIT_CLKS(50)) bus_master_i (
		.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
		.cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in),
		.cmd_data_in(cmd_data_in), .cmd_len_in(cmd_len_in), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .done_out(done), .nack_out(nack), .link(serial_link_if_i)
	);

	link_checker link_checker_i (
		.link_clk(link_clk), .rst_in(rst_in), .scl(serial_link_if_i.scl),
		.sda(serial_link_if_i.sda), .sda_dev_out(serial_link_if_i.sda_dev_out),
		.sda_dev_oe_n(serial_link_if_i.sda_dev_oe_n),
		.sda_host_out(serial_link_if_i.sda_host_out),
		.sda_host_oe_n(serial_link_if_i.sda_host_oe_n)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// The link clock is offset so its edges never line up with clk_in.
	initial
	begin
		link_clk = 1'b0;
		#3.7;
		forever #6 link_clk = ~link_clk;
	end

	// ------------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic fail(input string msg);
		errors++;
		$display("Error at %0t: %s", $time, msg);
	endtask

	// ------------------------------------------------------------------
	// Command driver with byte-array model
	// ------------------------------------------------------------------
	// Polling on a busy device has no limit in the master, so the wait is capped here.
	task automatic run(input op_t op, input logic [7:0] a, input logic [7:0] d,
			input logic [7:0] len);
		int k;
		int cnt;
		int ea;
		cnt = 0;
		ea = (op == OP_CUR_READ) ? ptr : int'(a);
		for (k = 0; k < 1000 && cmd_ready !== 1'b1; k++)
			@(negedge clk_in);
		if (cmd_ready !== 1'b1)
		begin
			fail("master never ready");
			close_out();
		end
		cmd_valid_in = 1'b1;
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_len_in = len;
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		for (k = 0; k < 40000; k++)
		begin
			@(posedge clk_in);
			#1;
			if (rd_valid === 1'b1)
			begin
				n_checks++;
				if (rd_data !== mem[ea]) fail("read byte differs");
				ea = (ea + 1) % 256;
				cnt++;
			end
			if (done === 1'b1)
				break;
		end
		if (done !== 1'b1)
		begin
			fail("command never finished");
			close_out();
		end
		n_checks++;
		if (op == OP_WRITE)
		begin
			if (nack !== wp_in) fail("data acknowledge wrong");
			if (wp_in === 1'b0 && busy !== 1'b1) fail("no write cycle after stop");
			if (wp_in === 1'b0)
				mem[a] = d;
			ptr = (wp_in === 1'b0) ? (int'(a) + 1) % 256 : int'(a);
		end
		else
		begin
			if (cnt !== int'(len) + 1) fail("read byte count wrong");
			ptr = ea;
		end
		@(negedge clk_in);
	endtask

	initial
	begin
		rst_in = 1'b1;
		wp_in = 1'b0;
		cmd_valid_in = 1'b0;
		cmd_op_in = OP_WRITE;
		cmd_addr_in = 8'h00;
		cmd_data_in = 8'h00;
		cmd_len_in = 8'h00;
		errors = 0;
		n_checks = 0;
		ptr = 0;
		void'($urandom(32'h4606075b));
		repeat (12) @(negedge clk_in);
		rst_in = 1'b0;
		for (i = 0; i < 5; i++)
			run(OP_WRITE, 8'(254 + i), 8'($urandom), 8'h00);
		$display("test back-to-back writes done");
		run(OP_RAND_READ, 8'hfe, 8'h00, 8'h03);
		run(OP_CUR_READ, 8'h00, 8'h00, 8'h00);
		$display("test wrapping reads done");
		wp_in = 1'b1;
		repeat (2) @(negedge clk_in);
		run(OP_WRITE, 8'h00, ~mem[0], 8'h00);
		wp_in = 1'b0;
		repeat (2) @(negedge clk_in);
		run(OP_CUR_READ, 8'h00, 8'h00, 8'h00);
		$display("test write protect done");
		for (i = 0; i < 4; i++)
		begin
			ra = 8'($urandom);
			run(OP_WRITE, ra, 8'($urandom), 8'h00);
			run(OP_RAND_READ, ra, 8'h00, 8'($urandom % 3));
		end
		$display("test random access done");
		close_out();
	end
endmodule
